// [ocu_pkg.sv]
package ocu_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] PRIM_OFF    = 8'h10;
  localparam logic [7:0] SEC_OFF     = 8'h20;
  localparam logic [7:0] STAT_OFF    = 8'h30;
  localparam logic [7:0] MASK_OFF    = 8'h34;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int ENABLE_BIT    = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int WIDE_BIT      = 5;
  localparam int FAULT_BIT     = 4;
  localparam int TBSEL_BIT     = 3;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_a02f;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CMP_RESET  = 32'h0000_0000;

  // ------------------------------------------------------------
  // Interrupt status bits
  // ------------------------------------------------------------
  localparam int EV_MATCH   = 0;
  localparam int EV_TRAIL   = 1;
  localparam int EV_FAULT   = 2;
  localparam logic [2:0] EV_RESET = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    MODE_OFF    = 3'b000,
    MODE_SET    = 3'b001,
    MODE_CLEAR  = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_SINGLE = 3'b100,
    MODE_TRAIN  = 3'b101,
    MODE_PWM    = 3'b110,
    MODE_PWMF   = 3'b111
  } ocu_mode_t;

endpackage

// [ocu_sync.sv]
`timescale 1ns/1ns
module ocu_sync (
  input  wire logic sys_clk, // Clock
  input  wire logic rst,     // Synchronous reset
  input  wire logic din,     // Asynchronous level
  output logic      dout     // Synchronised level
);

  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule

// [ocu_match.sv]
`timescale 1ns/1ns
module ocu_match (
  input  wire logic        sys_clk,   // Clock
  input  wire logic        rst,       // Synchronous reset
  input  wire logic [31:0] tbA,       // First timebase count
  input  wire logic [31:0] tbB,       // Second timebase count
  input  wire logic        tbSel,     // Timebase select
  input  wire logic        wide,      // 32-bit compare
  input  wire logic [31:0] primVal,   // Primary compare value
  input  wire logic [31:0] secVal,    // Secondary compare value
  output logic             primHit,   // Registered primary match
  output logic             secHit     // Registered secondary match
);

  logic [31:0] count;
  logic        next_primHit;
  logic        next_secHit;

  function automatic logic eqw(input logic [31:0] a, input logic [31:0] b,
                               input logic w);
    eqw = w ? (a == b) : (a[15:0] == b[15:0]);
  endfunction

  always_comb begin
    count        = tbSel ? tbB : tbA;
    next_primHit = eqw(count, primVal, wide);
    next_secHit  = eqw(count, secVal, wide);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      primHit <= 1'b0;
      secHit  <= 1'b0;
    end else begin
      primHit <= next_primHit;
      secHit  <= next_secHit;
    end
  end

endmodule

// [ocu_top.sv]
`timescale 1ns/1ns
// Operation
// - Enable bit 15 switches the unit on; cleared keeps it off.
// - Idle-stop bit 13 halts the unit while the device idles.
// - Wide bit 5 selects 32-bit compare; clear compares low 16 bits.
// - Fault flag bit 4 set by hardware; software writes ignored.
// - Fault flag reads zero unless mode is 111.
// - Timebase bit 3 picks second timebase when set, first otherwise.
// - Modes 111 and 110 give PWM; only 111 honours fault input.
// - Mode 101 starts low then pulses every timer period.
// - Mode 100 starts low then gives exactly one pulse.
// - Mode 011 toggles the pin on every primary compare match.
// - Mode 010 starts high, match forces pin low.
// - Mode 001 starts low, match forces pin high.
// - Mode 000 disables compare activity.
// - Unimplemented control bits ignore writes and read zero.
module ocu_top (
  input  wire logic        sys_clk,    // 250 MHz clock
  input  wire logic        rst,        // Synchronous reset, high
  input  wire logic        hsel,       // AHB select
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB ready in
  output logic [31:0]      hrdata,     // AHB read data
  output logic             hreadyout,  // AHB ready out
  output logic             hresp,      // AHB response
  input  wire logic [31:0] tbA,        // First timebase count
  input  wire logic [31:0] tbB,        // Second timebase count
  input  wire logic        idleMode,   // Device idle level
  input  wire logic        faultIn,    // Fault pin, active high
  output logic             compareOut, // Compare output pin
  output logic             irq         // Level interrupt
);

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] primVal;
  logic [31:0] secVal;
  logic [2:0]  evStat;
  logic [2:0]  evMask;
  logic        faultFlag;
  logic        oneDone;
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [2:0]  lastMode;
  logic        lastRun;

  logic [31:0] next_ctrl;
  logic [31:0] next_primVal;
  logic [31:0] next_secVal;
  logic [2:0]  next_evStat;
  logic [2:0]  next_evMask;
  logic        next_faultFlag;
  logic        next_oneDone;
  logic        next_wrPend;
  logic [7:0]  next_wrAddr;
  logic [2:0]  next_lastMode;
  logic        next_lastRun;
  logic        next_compareOut;
  logic [31:0] next_hrdata;
  logic        next_irq;

  logic        faultSync;
  logic        primHit;
  logic        secHit;
  logic        addrPhase;
  logic        run;
  logic        reconfig;
  logic        cmpActive;
  logic [2:0]  swEvStat;
  ocu_pkg::ocu_mode_t mode;
  logic [31:0] ctrlRead;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  ocu_sync u_fault_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (faultIn),
    .dout    (faultSync)
  );

  ocu_match u_match (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tbA     (tbA),
    .tbB     (tbB),
    .tbSel   (ctrl[ocu_pkg::TBSEL_BIT]),
    .wide    (ctrl[ocu_pkg::WIDE_BIT]),
    .primVal (primVal),
    .secVal  (secVal),
    .primHit (primHit),
    .secHit  (secHit)
  );

  // ------------------------------------------------------------
  // Bus slave and registers
  // ------------------------------------------------------------
  always_comb begin
    mode      = ocu_pkg::ocu_mode_t'(ctrl[2:0]);
    addrPhase = hsel && hready && (htrans == ocu_pkg::HTRANS_NONSEQ);
    run       = ctrl[ocu_pkg::ENABLE_BIT]
                && !(ctrl[ocu_pkg::IDLE_STOP_BIT] && idleMode);
    ctrlRead  = ctrl & ocu_pkg::CTRL_WMASK;
    ctrlRead[ocu_pkg::FAULT_BIT] = faultFlag && (mode == ocu_pkg::MODE_PWMF);
    next_wrPend = addrPhase && hwrite;
    next_wrAddr = haddr[7:0];
    next_ctrl    = ctrl;
    next_primVal = primVal;
    next_secVal  = secVal;
    next_evMask  = evMask;
    swEvStat     = evStat;
    if (wrPend) begin
      unique case (wrAddr)
        ocu_pkg::CTRL_OFF: next_ctrl = hwdata & ocu_pkg::CTRL_WMASK;
        ocu_pkg::PRIM_OFF: next_primVal = hwdata;
        ocu_pkg::SEC_OFF:  next_secVal = hwdata;
        ocu_pkg::STAT_OFF: swEvStat = evStat & ~hwdata[2:0];
        ocu_pkg::MASK_OFF: next_evMask = hwdata[2:0];
        default: ;
      endcase
    end
    next_hrdata = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        ocu_pkg::CTRL_OFF: next_hrdata = ctrlRead;
        ocu_pkg::PRIM_OFF: next_hrdata = primVal;
        ocu_pkg::SEC_OFF:  next_hrdata = secVal;
        ocu_pkg::STAT_OFF: next_hrdata = {29'h0, evStat};
        ocu_pkg::MASK_OFF: next_hrdata = {29'h0, evMask};
        default:           next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Compare output engine
  // ------------------------------------------------------------
  always_comb begin
    next_lastMode   = ctrl[2:0];
    next_lastRun    = ctrl[ocu_pkg::ENABLE_BIT];
    // Leaving idle resumes without putting the pin back to its initial level
    reconfig        = (ctrl[2:0] != lastMode) || (ctrl[ocu_pkg::ENABLE_BIT] && !lastRun);
    cmpActive       = run && (mode != ocu_pkg::MODE_OFF);
    next_compareOut = compareOut;
    next_oneDone    = oneDone;
    next_faultFlag  = faultFlag;
    if (!ctrl[ocu_pkg::ENABLE_BIT]) begin
      next_compareOut = 1'b0;
    end else if (reconfig) begin
      next_oneDone   = 1'b0;
      next_faultFlag = 1'b0;
      unique case (mode)
        ocu_pkg::MODE_CLEAR:  next_compareOut = 1'b1;
        ocu_pkg::MODE_TOGGLE: next_compareOut = compareOut;
        default:              next_compareOut = 1'b0;
      endcase
    end else if (run) begin
      unique case (mode)
        ocu_pkg::MODE_OFF:    next_compareOut = compareOut;
        ocu_pkg::MODE_SET:    if (primHit) next_compareOut = 1'b1;
        ocu_pkg::MODE_CLEAR:  if (primHit) next_compareOut = 1'b0;
        ocu_pkg::MODE_TOGGLE: if (primHit) next_compareOut = !compareOut;
        ocu_pkg::MODE_SINGLE: begin
          if (primHit && !oneDone) next_compareOut = 1'b1;
          if (secHit && compareOut) begin
            next_compareOut = 1'b0;
            next_oneDone    = 1'b1;
          end
        end
        ocu_pkg::MODE_TRAIN: begin
          if (primHit) next_compareOut = 1'b1;
          else if (secHit) next_compareOut = 1'b0;
        end
        ocu_pkg::MODE_PWM, ocu_pkg::MODE_PWMF: begin
          if (primHit) next_compareOut = 1'b1;
          else if (secHit) next_compareOut = 1'b0;
          if (mode == ocu_pkg::MODE_PWMF && (faultSync || faultFlag)) begin
            next_compareOut = 1'b0;
            next_faultFlag  = 1'b1;
          end
        end
      endcase
    end
    next_evStat = swEvStat;
    // Set wins over a same-cycle clear
    next_evStat[ocu_pkg::EV_MATCH] = next_evStat[ocu_pkg::EV_MATCH] | (cmpActive && primHit);
    next_evStat[ocu_pkg::EV_TRAIL] = next_evStat[ocu_pkg::EV_TRAIL] | (cmpActive && secHit);
    next_evStat[ocu_pkg::EV_FAULT] = next_evStat[ocu_pkg::EV_FAULT]
                                     | (next_faultFlag && !faultFlag);
    next_irq = |(next_evStat & next_evMask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl       <= ocu_pkg::CTRL_RESET;
      primVal    <= ocu_pkg::CMP_RESET;
      secVal     <= ocu_pkg::CMP_RESET;
      evStat     <= ocu_pkg::EV_RESET;
      evMask     <= ocu_pkg::EV_RESET;
      faultFlag  <= 1'b0;
      oneDone    <= 1'b0;
      wrPend     <= 1'b0;
      wrAddr     <= 8'h00;
      lastMode   <= 3'h0;
      lastRun    <= 1'b0;
      compareOut <= 1'b0;
      hrdata     <= 32'h0000_0000;
      irq        <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      primVal    <= next_primVal;
      secVal     <= next_secVal;
      evStat     <= next_evStat;
      evMask     <= next_evMask;
      faultFlag  <= next_faultFlag;
      oneDone    <= next_oneDone;
      wrPend     <= next_wrPend;
      wrAddr     <= next_wrAddr;
      lastMode   <= next_lastMode;
      lastRun    <= next_lastRun;
      compareOut <= next_compareOut;
      hrdata     <= next_hrdata;
      irq        <= next_irq;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_off_low;
    @(posedge sys_clk) disable iff (rst)
      !ctrl[ocu_pkg::ENABLE_BIT] |=> !compareOut;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output high while off");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (rst)
      (ctrl[ocu_pkg::ENABLE_BIT] && ctrl[ocu_pkg::IDLE_STOP_BIT] && idleMode && !reconfig)
      |=> $stable(compareOut);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("output moved in idle");

  property p_fault_read;
    @(posedge sys_clk) disable iff (rst)
      (mode != ocu_pkg::MODE_PWMF) |-> !ctrlRead[ocu_pkg::FAULT_BIT];
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault flag visible");

  property p_unimpl;
    @(posedge sys_clk) disable iff (rst) (ctrl & ~ocu_pkg::CTRL_WMASK) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_set_mode;
    @(posedge sys_clk) disable iff (rst)
      (run && !reconfig && mode == ocu_pkg::MODE_SET && primHit) |=> compareOut;
  endproperty
  a_set_mode: assert property (p_set_mode) else $error("set mode missed");

  property p_clr_mode;
    @(posedge sys_clk) disable iff (rst)
      (run && !reconfig && mode == ocu_pkg::MODE_CLEAR && primHit) |=> !compareOut;
  endproperty
  a_clr_mode: assert property (p_clr_mode) else $error("clear mode missed");

  property p_toggle;
    @(posedge sys_clk) disable iff (rst)
      (run && !reconfig && mode == ocu_pkg::MODE_TOGGLE && primHit)
      |=> (compareOut != $past(compareOut));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  sequence s_fault_seen;
    run && !reconfig && mode == ocu_pkg::MODE_PWMF && faultSync;
  endsequence
  property p_fault_force;
    @(posedge sys_clk) disable iff (rst)
      s_fault_seen |=> (!compareOut && faultFlag);
  endproperty
  a_fault_force: assert property (p_fault_force) else $error("fault not forced");

  property p_single_once;
    @(posedge sys_clk) disable iff (rst)
      (run && !reconfig && mode == ocu_pkg::MODE_SINGLE && oneDone) |=> !compareOut;
  endproperty
  a_single_once: assert property (p_single_once) else $error("second pulse");

endmodule

// [ocu_load.sv]
`timescale 1ns/1ns
module ocu_load (
  input  wire logic sys_clk,  // Clock
  input  wire logic rst,      // Synchronous reset
  input  wire logic pinLevel, // Compare output pin
  input  wire logic faultReq, // Bench asks for a fault
  output logic      faultIn,  // Fault pin back to the unit
  output int        pulses    // Rising edges seen on the pin
);
  logic lastLevel;

  always_ff @(posedge sys_clk) begin
    lastLevel <= pinLevel;
    faultIn   <= faultReq;
    if (rst) begin
      pulses <= 0;
    end else if (pinLevel && !lastLevel) begin
      pulses <= pulses + 1;
    end
  end
endmodule

// [output_compare_unit_tb.sv]
`timescale 1ns/1ns
module output_compare_unit_tb;
  logic        sys_clk, rst, hwrite, idleMode, faultReq, faultIn;
  logic        compareOut, irq, hreadyout, hresp, shotDone;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, tbA, tbB, lfsr, rd, pv, sv;
  int          nFail, checked, pulses, modelPin;

  ocu_top u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tbA(tbA), .tbB(tbB), .idleMode(idleMode), .faultIn(faultIn),
    .compareOut(compareOut), .irq(irq));
  ocu_load u_load (.sys_clk(sys_clk), .rst(rst), .pinLevel(compareOut),
    .faultReq(faultReq), .faultIn(faultIn), .pulses(pulses));

  // ------------------------------------------------------------
  // Bus, model and compare helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= ocu_pkg::HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
    cmp({31'h0, hresp}, 32'h0);
  endtask

  task automatic pin;
    cmp({31'h0, compareOut}, modelPin);
  endtask

  task automatic cfg(input logic [31:0] c);
    bus(1'b1, ocu_pkg::CTRL_OFF, 32'h0);
    repeat (2) @(posedge sys_clk);
    bus(1'b1, ocu_pkg::CTRL_OFF, c);
    modelPin = (c[15] && c[2:0] == 3'b010) ? 1 : 0;
    shotDone = 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Count shows for one cycle only, so every match is a single event
  task automatic hit(input logic b, input logic [31:0] v);
    @(posedge sys_clk);
    if (b) tbB <= v;
    else tbA <= v;
    @(posedge sys_clk);
    tbA <= 32'h0;
    tbB <= 32'h0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic mdl(input logic [2:0] m, input logic prim);
    if (m == 3'b001 && prim) modelPin = 1;
    if (m == 3'b010 && prim) modelPin = 0;
    if (m == 3'b011 && prim) modelPin = 1 - modelPin;
    if (m >= 3'b100 && prim && !(m == 3'b100 && shotDone)) modelPin = 1;
    if (m >= 3'b100 && !prim && modelPin == 1) shotDone = 1'b1;
    if (m >= 3'b100 && !prim) modelPin = 0;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    {hwrite, idleMode, faultReq, shotDone} = 4'h0;
    {htrans, haddr, hwdata, tbA, tbB} = '0;
    {nFail, checked, modelPin} = 0;
    lfsr = 32'h1c12;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(ocu_pkg::CTRL_OFF, ocu_pkg::CTRL_RESET);
    rdc(ocu_pkg::STAT_OFF, 32'h0);
    rdc(8'h40, 32'h0);
    lfsr = nextRand(lfsr);
    pv = lfsr | 32'h0001_0001;
    sv = pv + 32'h10;
    bus(1'b1, ocu_pkg::PRIM_OFF, pv);
    bus(1'b1, ocu_pkg::SEC_OFF, sv);
    bus(1'b1, ocu_pkg::CTRL_OFF, 32'hffff_ffff);
    rdc(ocu_pkg::CTRL_OFF, 32'h0000_a02f);
    for (int m = 0; m < 8; m++) begin
      cfg(32'h0000_8020 | m);
      pin();
      for (int k = 0; k < 3; k++) begin
        hit(1'b0, (k == 1) ? sv : pv);
        mdl(m[2:0], k != 1);
        pin();
      end
    end
    cfg(32'h0000_8009);
    hit(1'b0, pv);
    pin();
    hit(1'b1, {16'h0, pv[15:0]});
    mdl(3'b001, 1'b1);
    pin();
    cfg(32'h0000_8029);
    hit(1'b1, {16'h0, pv[15:0]});
    pin();
    hit(1'b1, pv);
    mdl(3'b001, 1'b1);
    pin();
    cfg(32'h0000_8027);
    hit(1'b0, pv);
    faultReq <= 1'b1;
    repeat (6) @(posedge sys_clk);
    modelPin = 0;
    pin();
    rdc(ocu_pkg::CTRL_OFF, 32'h0000_8037);
    bus(1'b1, ocu_pkg::CTRL_OFF, 32'h0000_8027);
    rdc(ocu_pkg::CTRL_OFF, 32'h0000_8037);
    cfg(32'h0000_8026);
    hit(1'b0, pv);
    mdl(3'b110, 1'b1);
    pin();
    rdc(ocu_pkg::CTRL_OFF, 32'h0000_8026);
    faultReq <= 1'b0;
    cfg(32'h0000_8021);
    bus(1'b1, ocu_pkg::STAT_OFF, 32'h7);
    bus(1'b1, ocu_pkg::MASK_OFF, 32'h0);
    hit(1'b0, pv);
    rdc(ocu_pkg::STAT_OFF, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, ocu_pkg::MASK_OFF, 32'h1);
    rdc(ocu_pkg::MASK_OFF, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, ocu_pkg::STAT_OFF, 32'h1);
    rdc(ocu_pkg::STAT_OFF, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    cfg(32'h0000_0021);
    hit(1'b0, pv);
    pin();
    cfg(32'h0000_a021);
    idleMode <= 1'b1;
    hit(1'b0, pv);
    pin();
    idleMode <= 1'b0;
    hit(1'b0, pv);
    mdl(3'b001, 1'b1);
    pin();
    cfg(32'h0000_8021);
    idleMode <= 1'b1;
    hit(1'b0, pv);
    mdl(3'b001, 1'b1);
    pin();
    cmp(pulses, 32'd17);
    conclude();
  end
endmodule
